/* hdl/rsie_pkg.sv */
// constants for the repeat, store, interlock and subtract-with-borrow execute block
package rsie_pkg;
   localparam int DW = 32;
   localparam int AW = 24;
   localparam int ADDR_W = 12;
   localparam int NUM_REGS = 28;
   localparam int FLT_REGS = 8;
   localparam int RN_W = 5;
   localparam logic [RN_W-1:0] LAST_REG = 5'h1b;
   // instruction fields
   localparam int OPC_MSB = 31;
   localparam int OPC_LSB = 23;
   localparam int G_MSB = 22;
   localparam int G_LSB = 21;
   localparam int R_MSB = 20;
   localparam int R_LSB = 16;
   localparam int IMM_MSB = 15;
   localparam int P_OP_MSB = 31;
   localparam int P_OP_LSB = 25;
   localparam int P_S2_MSB = 24;
   localparam int P_S2_LSB = 22;
   localparam int P_S1_MSB = 18;
   localparam int P_S1_LSB = 16;
   localparam int P_D1_MOD_MSB = 15;
   localparam int P_D1_MOD_LSB = 11;
   localparam int P_D2_MOD_MSB = 7;
   localparam int P_D2_MOD_LSB = 3;
   localparam logic [4:0] PAR_MOD_LIMIT = 5'h18;
   // opcodes
   localparam logic [8:0] OP_SINGLE_LOOP_OP = 9'h027;
   localparam logic [8:0] OP_STF = 9'h028;
   localparam logic [8:0] OP_STORE_FLOAT_LOCKED_OP = 9'h029;
   localparam logic [8:0] OP_STI = 9'h02a;
   localparam logic [8:0] OP_STORE_INTEGER_LOCKED_OP = 9'h02b;
   localparam logic [8:0] OP_INTERLOCK_BEGIN_OP = 9'h02c;
   localparam logic [8:0] OP_SUBTRACT_BORROW_OP = 9'h036;
   localparam logic [6:0] PAR_STF = 7'h60;
   localparam logic [6:0] PAR_STI = 7'h61;
   // addressing field
   localparam logic [1:0] G_REG = 2'h0;
   localparam logic [1:0] G_DIR = 2'h1;
   localparam logic [1:0] G_IND = 2'h2;
   localparam logic [1:0] G_IMM = 2'h3;
   // status bit positions
   localparam int ST_C = 0;
   localparam int ST_V = 1;
   localparam int ST_Z = 2;
   localparam int ST_N = 3;
   localparam int ST_UF = 4;
   localparam int ST_LV = 5;
   localparam int ST_LUF = 6;
   localparam int ST_OVM = 7;
   localparam int ST_RM = 8;
   localparam int ST_S = 9;
   localparam logic [DW-1:0] STATUS_WMASK = 32'h0000_03ff;
   localparam logic [DW-1:0] STATUS_RST = 32'h0000_0000;
   localparam logic [DW-1:0] MAX_POS = 32'h7fff_ffff;
   localparam logic [DW-1:0] MAX_NEG = 32'h8000_0000;
   // {ext_flag_1, ext_flag_0} codes
   localparam logic [1:0] ILK_IDLE = 2'h3;
   localparam logic [1:0] ILK_SIG = 2'h0;
   localparam logic [1:0] ILK_END = 2'h2;
   // register map
   localparam logic [ADDR_W-1:0] A_RF_LAST = 12'h06c;
   localparam logic [ADDR_W-1:0] A_STATUS = 12'h080;
   localparam logic [ADDR_W-1:0] A_LOOP_COUNT = 12'h084;
   localparam logic [ADDR_W-1:0] A_LOOP_START = 12'h088;
   localparam logic [ADDR_W-1:0] A_LOOP_END = 12'h08c;
   localparam logic [ADDR_W-1:0] A_LATCH = 12'h090;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_ILKW = 3'b010,
      S_LEND = 3'b100
   } rsie_state_t;
endpackage

/* hdl/rsie_exec.sv */
// execute block: single repeat setup, interlock flags, stores and subtract with borrow
`timescale 1ns/1ns
`default_nettype none
module rsie_exec (
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic CLK_EN,
   input wire logic INSTR_VALID,
   output logic INSTR_READY,
   input wire logic [rsie_pkg::DW-1:0] INSTR_WORD,
   input wire logic [rsie_pkg::AW-1:0] NEXT_PC,
   input wire logic [rsie_pkg::DW-1:0] OPER_DATA,
   input wire logic [rsie_pkg::AW-1:0] OPER_ADDR,
   input wire logic [rsie_pkg::AW-1:0] OPER_ADDR2,
   input wire logic BUS_RDY,
   input wire logic EXT_ACK,
   output logic EXT_FLAG_0,
   output logic EXT_FLAG_1,
   output logic FETCH_FROM_LATCH,
   output logic ILLEGAL_OP,
   output logic MEM_A_WE,
   output logic [rsie_pkg::AW-1:0] MEM_A_ADDR,
   output logic [rsie_pkg::DW-1:0] MEM_A_WDATA,
   output logic MEM_B_WE,
   output logic [rsie_pkg::AW-1:0] MEM_B_ADDR,
   output logic [rsie_pkg::DW-1:0] MEM_B_WDATA,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [rsie_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   input wire logic [rsie_pkg::DW-1:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   output logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   input wire logic [rsie_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [rsie_pkg::DW-1:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP
);
   import rsie_pkg::*;

   // ********************************
   // reset and pin synchronisers
   // ********************************
   logic rst_s1_ff, rst_n;
   logic ack_s1_ff, ack_s2_ff, rdy_s1_ff, rdy_s2_ff;
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_s1_ff <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_n <= rst_s1_ff;
      end
   end
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ack_s1_ff <= 1'b0;
         ack_s2_ff <= 1'b0;
         rdy_s1_ff <= 1'b0;
         rdy_s2_ff <= 1'b0;
      end else if (CLK_EN) begin
         ack_s1_ff <= EXT_ACK;
         ack_s2_ff <= ack_s1_ff;
         rdy_s1_ff <= BUS_RDY;
         rdy_s2_ff <= rdy_s1_ff;
      end
   end

   // ********************************
   // state
   // ********************************
   rsie_state_t state_ff, nxt_state;
   logic [DW-1:0] rf_ff [NUM_REGS];
   logic [DW-1:0] nxt_rf [NUM_REGS];
   logic [DW-1:0] status_ff, nxt_status, rc_ff, nxt_rc, latch_ff, nxt_latch;
   logic [AW-1:0] rs_ff, nxt_rs, re_ff, nxt_re;
   logic latch_vld_ff, nxt_latch_vld;
   logic [1:0] flags_ff, nxt_flags;
   logic ill_ff, nxt_ill, a_we_ff, nxt_a_we, b_we_ff, nxt_b_we;
   logic [AW-1:0] a_addr_ff, nxt_a_addr, b_addr_ff, nxt_b_addr;
   logic [DW-1:0] a_data_ff, nxt_a_data, b_data_ff, nxt_b_data;
   logic aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold, bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
   logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
   logic [DW-1:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
   logic [3:0] wstrb_ff, nxt_wstrb;
   logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;

   // decode
   logic rpt_exec, cur_valid, is_stf, is_sti, is_lock, is_par, is_store, go, axi_wr;
   logic [DW-1:0] cur;
   logic [8:0] opc;
   logic [1:0] gm;
   logic [RN_W-1:0] rn, srn;
   logic [DW-1:0] opnd_u, opnd_s, dval, res;
   logic [DW:0] wide, ubw;
   logic ovf, sp_ok, legal, par_same;

   function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, input logic [DW-1:0] n, input logic [3:0] s);
      logic [DW-1:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = n[i*8 +: 8];
         end
      end
      return r;
   endfunction

   always_comb begin
      rpt_exec = status_ff[ST_S] & latch_vld_ff;
      // repeated instruction is taken from the latch, not from memory
      cur = rpt_exec ? latch_ff : INSTR_WORD;
      cur_valid = rpt_exec | INSTR_VALID;
      opc = cur[OPC_MSB:OPC_LSB];
      gm = cur[G_MSB:G_LSB];
      rn = cur[R_MSB:R_LSB];
      srn = cur[RN_W-1:0];
      is_stf = (opc == OP_STF) || (opc == OP_STORE_FLOAT_LOCKED_OP);
      is_sti = (opc == OP_STI) || (opc == OP_STORE_INTEGER_LOCKED_OP);
      is_lock = (opc == OP_STORE_FLOAT_LOCKED_OP) || (opc == OP_STORE_INTEGER_LOCKED_OP);
      is_par = (cur[P_OP_MSB:P_OP_LSB] == PAR_STF) || (cur[P_OP_MSB:P_OP_LSB] == PAR_STI);
      is_store = is_stf || is_sti || is_par;
      sp_ok = (gm != G_REG) || (srn <= LAST_REG);
      // operand kind from the two-bit field
      case (gm)
         G_REG: opnd_u = (srn <= LAST_REG) ? rf_ff[srn] : '0;
         G_IMM: opnd_u = {{(DW-IMM_MSB-1){1'b0}}, cur[IMM_MSB:0]};
         default: opnd_u = OPER_DATA;
      endcase
      opnd_s = (gm == G_IMM) ? {{(DW-IMM_MSB-1){cur[IMM_MSB]}}, cur[IMM_MSB:0]} : opnd_u;
      dval = (rn <= LAST_REG) ? rf_ff[rn] : '0;
      // signed dst - src - carry, borrow from the unsigned view
      wide = {dval[DW-1], dval} - {opnd_s[DW-1], opnd_s} - {{DW{1'b0}}, status_ff[ST_C]};
      ubw = {1'b0, dval} - {1'b0, opnd_s} - {{DW{1'b0}}, status_ff[ST_C]};
      ovf = wide[DW] != wide[DW-1];
      // clamp only when saturating mode is on
      if (ovf && status_ff[ST_OVM]) begin
         res = dval[DW-1] ? MAX_NEG : MAX_POS;
      end else begin
         res = wide[DW-1:0];
      end
      if (is_par) begin
         legal = (cur[P_D1_MOD_MSB:P_D1_MOD_LSB] < PAR_MOD_LIMIT) && (cur[P_D2_MOD_MSB:P_D2_MOD_LSB] < PAR_MOD_LIMIT);
      end else if (is_stf) begin
         legal = ((gm == G_DIR) || (gm == G_IND)) && (rn < RN_W'(FLT_REGS));
      end else if (is_sti) begin
         legal = ((gm == G_DIR) || (gm == G_IND)) && (rn <= LAST_REG);
      end else if (opc == OP_SUBTRACT_BORROW_OP) begin
         legal = sp_ok && (rn <= LAST_REG);
      end else if (opc == OP_SINGLE_LOOP_OP) begin
         legal = sp_ok;
      end else begin
         legal = 1'b1;
      end
      par_same = OPER_ADDR == OPER_ADDR2;
      // stores wait for bus ready; nothing else does
      go = CLK_EN && (state_ff == S_IDLE) && cur_valid && (!is_store || rdy_s2_ff);
      INSTR_READY = CLK_EN && (state_ff == S_IDLE) && !rpt_exec && (!is_store || rdy_s2_ff);
      axi_wr = CLK_EN && aw_hold_ff && w_hold_ff && !bvalid_ff;
   end

   // ********************************
   // next state: bus slave and execute
   // ********************************
   always_comb begin
      nxt_state = state_ff;
      nxt_rf = rf_ff;
      nxt_status = status_ff;
      nxt_rc = rc_ff;
      nxt_rs = rs_ff;
      nxt_re = re_ff;
      nxt_latch = latch_ff;
      nxt_latch_vld = latch_vld_ff;
      nxt_flags = flags_ff;
      nxt_ill = 1'b0;
      nxt_a_we = 1'b0;
      nxt_b_we = 1'b0;
      nxt_a_addr = a_addr_ff;
      nxt_b_addr = b_addr_ff;
      nxt_a_data = a_data_ff;
      nxt_b_data = b_data_ff;
      nxt_aw_hold = aw_hold_ff;
      nxt_awaddr = awaddr_ff;
      nxt_w_hold = w_hold_ff;
      nxt_wdata = wdata_ff;
      nxt_wstrb = wstrb_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      // write channels are taken independently, in either order
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         nxt_aw_hold = 1'b1;
         nxt_awaddr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         nxt_w_hold = 1'b1;
         nxt_wdata = S_AXI_WDATA;
         nxt_wstrb = S_AXI_WSTRB;
      end
      if (bvalid_ff && S_AXI_BREADY) begin
         nxt_bvalid = 1'b0;
      end
      if (axi_wr) begin
         nxt_aw_hold = 1'b0;
         nxt_w_hold = 1'b0;
         nxt_bvalid = 1'b1;
         nxt_bresp = RESP_OKAY;
         if (awaddr_ff <= A_RF_LAST && awaddr_ff[1:0] == 2'h0) begin
            nxt_rf[awaddr_ff[RN_W+1:2]] = merge(rf_ff[awaddr_ff[RN_W+1:2]], wdata_ff, wstrb_ff);
         end else if (awaddr_ff == A_STATUS) begin
            nxt_status = merge(status_ff, wdata_ff, wstrb_ff) & STATUS_WMASK;
         end else if (awaddr_ff == A_LOOP_COUNT) begin
            nxt_rc = merge(rc_ff, wdata_ff, wstrb_ff);
         end else if (awaddr_ff != A_LOOP_START && awaddr_ff != A_LOOP_END && awaddr_ff != A_LATCH) begin
            nxt_bresp = RESP_SLVERR;
         end
      end
      if (rvalid_ff && S_AXI_RREADY) begin
         nxt_rvalid = 1'b0;
      end
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = RESP_OKAY;
         if (S_AXI_ARADDR <= A_RF_LAST && S_AXI_ARADDR[1:0] == 2'h0) begin
            nxt_rdata = rf_ff[S_AXI_ARADDR[RN_W+1:2]];
         end else begin
            case (S_AXI_ARADDR)
               A_STATUS: nxt_rdata = status_ff;
               A_LOOP_COUNT: nxt_rdata = rc_ff;
               A_LOOP_START: nxt_rdata = {{(DW-AW){1'b0}}, rs_ff};
               A_LOOP_END: nxt_rdata = {{(DW-AW){1'b0}}, re_ff};
               A_LATCH: nxt_rdata = latch_ff;
               default: begin
                  nxt_rdata = '0;
                  nxt_rresp = RESP_SLVERR;
               end
            endcase
         end
      end
      // execute wins over a software write in the same cycle
      case (state_ff)
         S_IDLE: begin
            nxt_flags = ILK_IDLE;
            if (go) begin
               // count and latch handled alongside execution, no extra cycle
               if (status_ff[ST_S] && opc != OP_SINGLE_LOOP_OP) begin
                  if (!latch_vld_ff) begin
                     nxt_latch = cur;
                     nxt_latch_vld = 1'b1;
                  end
                  if (rc_ff == '0) begin
                     nxt_status[ST_S] = 1'b0;
                     nxt_status[ST_RM] = 1'b0;
                     nxt_latch_vld = 1'b0;
                  end else begin
                     nxt_rc = rc_ff - 1'b1;
                  end
               end
               if (!legal) begin
                  nxt_ill = 1'b1;
               end else if (opc == OP_SINGLE_LOOP_OP) begin
                  nxt_rc = opnd_u;
                  nxt_status[ST_RM] = 1'b1;
                  nxt_status[ST_S] = 1'b1;
                  // both loop addresses take the next address
                  nxt_rs = NEXT_PC;
                  nxt_re = NEXT_PC;
                  nxt_latch_vld = 1'b0;
               end else if (is_par) begin
                  // second pair (src2 to OPER_ADDR2) owns port A; B drops on a clash
                  nxt_a_we = 1'b1;
                  nxt_a_addr = OPER_ADDR2;
                  nxt_a_data = rf_ff[cur[P_S2_MSB:P_S2_LSB]];
                  nxt_b_we = !par_same;
                  nxt_b_addr = OPER_ADDR;
                  nxt_b_data = rf_ff[cur[P_S1_MSB:P_S1_LSB]];
               end else if (is_stf || is_sti) begin
                  // register to memory, no flag change
                  nxt_a_we = 1'b1;
                  nxt_a_addr = OPER_ADDR;
                  nxt_a_data = rf_ff[rn];
                  if (is_lock) begin
                     nxt_state = S_LEND;
                  end
               end else if (opc == OP_INTERLOCK_BEGIN_OP) begin
                  nxt_flags = ILK_SIG;
                  nxt_state = S_ILKW;
               end else if (opc == OP_SUBTRACT_BORROW_OP) begin
                  nxt_rf[rn] = res;
                  nxt_status[ST_N] = res[DW-1];
                  nxt_status[ST_Z] = res == '0;
                  nxt_status[ST_V] = ovf;
                  nxt_status[ST_C] = ubw[DW];
                  nxt_status[ST_UF] = 1'b0;
                  nxt_status[ST_LV] = nxt_status[ST_LV] | ovf;
               end
            end
         end
         S_ILKW: begin
            // only the acknowledge ends the wait; bus ready is not looked at
            if (CLK_EN && ack_s2_ff) begin
               nxt_flags = ILK_IDLE;
               nxt_state = S_IDLE;
            end
         end
         S_LEND: begin
            // end-of-interlock code follows the store by one cycle
            nxt_flags = ILK_END;
            nxt_state = S_IDLE;
         end
         default: begin
            nxt_state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= S_IDLE;
         for (int i = 0; i < NUM_REGS; i++) begin
            rf_ff[i] <= '0;
         end
         status_ff <= STATUS_RST;
         rc_ff <= '0;
         rs_ff <= '0;
         re_ff <= '0;
         latch_ff <= '0;
         latch_vld_ff <= 1'b0;
         flags_ff <= ILK_IDLE;
         ill_ff <= 1'b0;
         a_we_ff <= 1'b0;
         b_we_ff <= 1'b0;
         a_addr_ff <= '0;
         b_addr_ff <= '0;
         a_data_ff <= '0;
         b_data_ff <= '0;
         aw_hold_ff <= 1'b0;
         awaddr_ff <= '0;
         w_hold_ff <= 1'b0;
         wdata_ff <= '0;
         wstrb_ff <= '0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= RESP_OKAY;
      end else if (CLK_EN) begin
         state_ff <= nxt_state;
         rf_ff <= nxt_rf;
         status_ff <= nxt_status;
         rc_ff <= nxt_rc;
         rs_ff <= nxt_rs;
         re_ff <= nxt_re;
         latch_ff <= nxt_latch;
         latch_vld_ff <= nxt_latch_vld;
         flags_ff <= nxt_flags;
         ill_ff <= nxt_ill;
         a_we_ff <= nxt_a_we;
         b_we_ff <= nxt_b_we;
         a_addr_ff <= nxt_a_addr;
         b_addr_ff <= nxt_b_addr;
         a_data_ff <= nxt_a_data;
         b_data_ff <= nxt_b_data;
         aw_hold_ff <= nxt_aw_hold;
         awaddr_ff <= nxt_awaddr;
         w_hold_ff <= nxt_w_hold;
         wdata_ff <= nxt_wdata;
         wstrb_ff <= nxt_wstrb;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
      end
   end

   // ********************************
   // outputs
   // ********************************
   assign S_AXI_AWREADY = CLK_EN && !aw_hold_ff;
   assign S_AXI_WREADY = CLK_EN && !w_hold_ff;
   assign S_AXI_BVALID = bvalid_ff;
   assign S_AXI_BRESP = bresp_ff;
   assign S_AXI_ARREADY = CLK_EN && !rvalid_ff;
   assign S_AXI_RVALID = rvalid_ff;
   assign S_AXI_RDATA = rdata_ff;
   assign S_AXI_RRESP = rresp_ff;
   assign EXT_FLAG_0 = flags_ff[0];
   assign EXT_FLAG_1 = flags_ff[1];
   assign FETCH_FROM_LATCH = status_ff[ST_S];
   assign ILLEGAL_OP = ill_ff;
   assign MEM_A_WE = a_we_ff;
   assign MEM_A_ADDR = a_addr_ff;
   assign MEM_A_WDATA = a_data_ff;
   assign MEM_B_WE = b_we_ff;
   assign MEM_B_ADDR = b_addr_ff;
   assign MEM_B_WDATA = b_data_ff;

   // ********************************
   // assertions
   // ********************************
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!rst_n);

   a_single_loop_op_count: assert property (go && legal && opc == OP_SINGLE_LOOP_OP && gm == G_IMM |=>
      rc_ff == {{(DW-IMM_MSB-1){1'b0}}, $past(cur[IMM_MSB:0])}) else $error("repeat count not loaded");
   a_single_loop_op_setup: assert property (go && legal && opc == OP_SINGLE_LOOP_OP |=>
      status_ff[ST_RM] && status_ff[ST_S] && rs_ff == $past(NEXT_PC) && re_ff == $past(NEXT_PC))
      else $error("repeat setup wrong");
   a_latch_only: assert property (status_ff[ST_S] && latch_vld_ff |-> !INSTR_READY)
      else $error("memory fetch during single repeat");
   a_ilk_hold: assert property (state_ff == S_ILKW && !ack_s2_ff |=> state_ff == S_ILKW && flags_ff == ILK_SIG)
      else $error("interlock wait left early");
   a_lock_end: assert property (go && legal && is_lock ##1 CLK_EN |=> flags_ff == ILK_END ##1 !CLK_EN || flags_ff == ILK_IDLE)
      else $error("interlock end not signalled");
   a_par_clash: assert property (go && legal && is_par && par_same |=> MEM_A_WE && !MEM_B_WE
      && MEM_A_WDATA == $past(rf_ff[cur[P_S2_MSB:P_S2_LSB]])) else $error("parallel clash wrong store kept");
   a_stf_range: assert property (go && is_stf && rn >= RN_W'(FLT_REGS) |=> !MEM_A_WE && ILLEGAL_OP)
      else $error("float store from high register");
   a_flags_keep: assert property (go && (is_store || opc == OP_INTERLOCK_BEGIN_OP || opc == OP_SINGLE_LOOP_OP) && !axi_wr |=>
      status_ff[ST_LUF:ST_C] == $past(status_ff[ST_LUF:ST_C])) else $error("flags changed by store");
   a_subtract_borrow_op_sat: assert property (go && legal && opc == OP_SUBTRACT_BORROW_OP && ovf && status_ff[ST_OVM] |=>
      (rf_ff[$past(rn)] == MAX_POS || rf_ff[$past(rn)] == MAX_NEG) && status_ff[ST_LV] && status_ff[ST_V])
      else $error("overflow not saturated");
   a_subtract_borrow_op_zero: assert property (go && legal && opc == OP_SUBTRACT_BORROW_OP |=>
      status_ff[ST_Z] == (rf_ff[$past(rn)] == '0)) else $error("zero flag mismatch");
endmodule
`default_nettype wire

/* test/rsie_mem_partner.sv */
// memory and interlock acknowledge model facing the execute block
`timescale 1ns/1ns
`default_nettype none
module rsie_mem_partner (
   input wire logic clk,
   input wire logic a_we,
   input wire logic [23:0] a_addr,
   input wire logic [31:0] a_wdata,
   input wire logic b_we,
   input wire logic [23:0] b_addr,
   input wire logic [31:0] b_wdata,
   input wire logic [1:0] flags,
   output logic bus_rdy,
   output logic ack
);
   import rsie_pkg::*;
   logic [31:0] mem [logic [23:0]];
   int stall = 0;
   int hold = 0;
   initial bus_rdy = 1'h1;
   initial ack = 1'h0;
   always @(posedge clk) begin
      // port b lands last, so an unsuppressed b write would win
      if (a_we) mem[a_addr] = a_wdata;
      if (b_we) mem[b_addr] = b_wdata;
      stall <= (a_we || b_we) ? 3 : (stall > 0 ? stall - 1 : 0);
      // slow bus: not ready after each store and during interlock wait
      bus_rdy <= stall == 0 && flags != ILK_SIG;
      hold <= flags == ILK_SIG ? hold + 1 : 0;
      // acknowledge comes late and drops once the signal code ends
      ack <= flags == ILK_SIG && hold > 4;
   end
endmodule
`default_nettype wire

/* test/rsie_exec_bench.sv */
// self-checking bench for the execute block
`timescale 1ns/1ns
`default_nettype none
module rsie_exec_bench;
   import rsie_pkg::*;
   logic clk = 0, rst_b = 0, iv = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic [31:0] iw = '0, wd = '0;
   logic [23:0] pc = '0, oa = '0;
   logic [11:0] awa = '0, ara = '0;
   logic [1:0] rsp;
   wire logic ir, f0, f1, ffl, ill, awe, bwe, awr, wr, bv, arr, rv, brd, ack;
   wire logic [23:0] aa, ba;
   wire logic [31:0] ad, bd, rdat;
   wire logic [1:0] rrs;
   int err_total = 0, checked = 0, n;
   rsie_exec rsie_exec_inst (.REF_CLK(clk), .RST_B(rst_b), .CLK_EN(1'h1), .INSTR_VALID(iv), .INSTR_READY(ir),
      .INSTR_WORD(iw), .NEXT_PC(pc), .OPER_DATA(32'h0000_0000), .OPER_ADDR(oa), .OPER_ADDR2(oa), .BUS_RDY(brd),
      .EXT_ACK(ack), .EXT_FLAG_0(f0), .EXT_FLAG_1(f1), .FETCH_FROM_LATCH(ffl), .ILLEGAL_OP(ill), .MEM_A_WE(awe),
      .MEM_A_ADDR(aa), .MEM_A_WDATA(ad), .MEM_B_WE(bwe), .MEM_B_ADDR(ba), .MEM_B_WDATA(bd), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_WDATA(wd),
      .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_BRESP(), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .S_AXI_RDATA(rdat),
      .S_AXI_RRESP(rrs));
   rsie_mem_partner rsie_mem_partner_inst (.clk(clk), .a_we(awe), .a_addr(aa), .a_wdata(ad), .b_we(bwe),
      .b_addr(ba), .b_wdata(bd), .flags({f1, f0}), .bus_rdy(brd), .ack(ack));
   always #10 clk = ~clk;
   task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
      end
   endtask
   // axi_wr, rchk and issue each leave one edge free so no signal is driven twice in a step
   task axi_wr(input logic [11:0] a, input logic [31:0] d);
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      br <= 1;
      for (n = 0; n < 50 && !bv; n++) begin
         @(posedge clk);
         if (awr) awv <= 0;
         if (wr) wv <= 0;
      end
      br <= 0;
      if (!bv) err_total++;
      @(posedge clk);
   endtask
   task rchk(input string s, input logic [11:0] a, input logic [31:0] e);
      ara <= a;
      arv <= 1;
      rr <= 1;
      for (n = 0; n < 50 && !rv; n++) begin
         @(posedge clk);
         if (arr) arv <= 0;
      end
      rr <= 0;
      rsp = rrs;
      if (!rv) err_total++;
      chk(s, rdat, e);
      @(posedge clk);
   endtask
   task issue(input logic [31:0] w, input logic [23:0] a);
      iw <= w;
      oa <= a;
      iv <= 1;
      for (n = 0; n < 50 && !(iv && ir); n++) @(posedge clk);
      iv <= 0;
      if (!ir) err_total++;
      @(posedge clk);
   endtask
   task wflag(input logic [1:0] c);
      for (n = 0; n < 60 && {f1, f0} !== c; n++) @(posedge clk);
      chk("flags", {30'h0, f1, f0}, {30'h0, c});
   endtask
   task close_out;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1;
      repeat (3) @(posedge clk);
      axi_wr(12'h004, 32'h0000_0010);
      axi_wr(A_STATUS, 32'h0000_0001);
      issue({OP_SUBTRACT_BORROW_OP, G_IMM, 5'h01, 16'h0005}, 24'h0);
      rchk("r1", 12'h004, 32'h0000_000a);
      rchk("st", A_STATUS, 32'h0000_0000);
      axi_wr(12'h008, MAX_NEG);
      axi_wr(A_STATUS, 32'h0000_0080);
      issue({OP_SUBTRACT_BORROW_OP, G_IMM, 5'h02, 16'h0001}, 24'h0);
      rchk("r2", 12'h008, MAX_NEG);
      rchk("st", A_STATUS, 32'h0000_00aa);
      $display("test subtract done");
      issue({OP_STI, G_DIR, 5'h01, 16'h0000}, 24'h00_0123);
      issue({OP_STI, G_REG, 5'h01, 16'h0000}, 24'h00_0124);
      // the illegal pulse stands one cycle; issue returns while it is still sampled high
      chk("ill", {31'h0, ill}, 32'h1);
      axi_wr(12'h00c, 32'h0000_0033);
      axi_wr(12'h010, 32'h0000_0044);
      issue({PAR_STI, 3'h3, 3'h0, 3'h4, 5'h00, 3'h0, 5'h00, 3'h0}, 24'h00_0200);
      issue({PAR_STF, 3'h4, 3'h0, 3'h3, 5'h00, 3'h0, 5'h00, 3'h0}, 24'h00_0201);
      rchk("st", A_STATUS, 32'h0000_00aa);
      chk("m123", rsie_mem_partner_inst.mem[24'h00_0123], 32'h0000_000a);
      chk("m124", rsie_mem_partner_inst.mem.exists(24'h00_0124), 32'h0);
      chk("m200", rsie_mem_partner_inst.mem[24'h00_0200], 32'h0000_0033);
      chk("m201", rsie_mem_partner_inst.mem[24'h00_0201], 32'h0000_0044);
      $display("test store done");
      issue({OP_INTERLOCK_BEGIN_OP, 23'h0}, 24'h0);
      wflag(ILK_SIG);
      wflag(ILK_IDLE);
      issue({OP_STORE_INTEGER_LOCKED_OP, G_IND, 5'h02, 16'h0000}, 24'h00_0300);
      wflag(ILK_END);
      chk("m300", rsie_mem_partner_inst.mem[24'h00_0300], MAX_NEG);
      $display("test interlock done");
      pc <= 24'h00_0124;
      issue({OP_SINGLE_LOOP_OP, G_IMM, 5'h1b, 16'h8000}, 24'h0);
      rchk("rc", A_LOOP_COUNT, 32'h0000_8000);
      rchk("rs", A_LOOP_START, 32'h0000_0124);
      rchk("re", A_LOOP_END, 32'h0000_0124);
      rchk("st", A_STATUS, 32'h0000_03aa);
      chk("ffl", {31'h0, ffl}, 32'h1);
      issue(32'hff80_0000, 24'h0);
      for (n = 0; n < 40000 && ffl; n++) @(posedge clk);
      chk("ffl end", {31'h0, ffl}, 32'h0);
      rchk("st", A_STATUS, 32'h0000_00aa);
      rchk("unmap", 12'h100, 32'h0000_0000);
      chk("resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
      $display("test repeat done");
      close_out();
   end
endmodule
`default_nettype wire
